// >>> hw/pdct_pkg.sv
package pdct_pkg;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam int ADDR_W = 2;
  localparam logic [ADDR_W-1:0] ADDR_COUNT = 2'h0;
  localparam logic [ADDR_W-1:0] ADDR_CTRL = 2'h1;

  // ----------------------------------------------------------------
  // control field positions and values
  // ----------------------------------------------------------------
  localparam int BIT_REQ = 7;
  localparam int BIT_MASK = 6;
  localparam int BIT_SRC = 5;
  localparam int BIT_GATE = 4;
  localparam int BIT_PCLR = 3;
  localparam int SEL_HI = 2;
  localparam int SEL_LO = 0;
  localparam int PRE_W = 7;
  localparam int SEL_CODES = 8;
  localparam logic [5:0] CFG_INIT = 6'h00;
  localparam logic [7:0] CNT_JUNK = 8'hff;
  localparam logic [7:0] CNT_ONE = 8'h01;
  localparam logic [7:0] BYTE_ZERO = 8'h00;

  // ----------------------------------------------------------------
  // clock source modes (source bit, gate bit)
  // ----------------------------------------------------------------
  localparam logic [1:0] MODE_INT = 2'h0;
  localparam logic [1:0] MODE_AND = 2'h1;
  localparam logic [1:0] MODE_OFF = 2'h2;
  localparam logic [1:0] MODE_PIN = 2'h3;

  // ----------------------------------------------------------------
  // register bus request
  // ----------------------------------------------------------------
  typedef struct packed {
    logic wr;
    logic rd;
    logic [ADDR_W-1:0] addr;
    logic [7:0] wdata;
  } pdct_bus_req_t;

endpackage : pdct_pkg

// >>> hw/pdct_timer.sv
// The address map and strobed register access were decided locally.
`timescale 1ns/100ps
module pdct_timer #(
  parameter int INSTR_DIV = 4
) (
  // clock and reset
  input wire logic mclk_in,
  input wire logic sys_rst_in,
  // register bus
  input wire pdct_pkg::pdct_bus_req_t bus_in,
  output logic [7:0] rd_data_out,
  // core side
  input wire logic cpu_imask_in,
  input wire logic stop_exec_in,
  output logic timer_irq_out,
  // external timer pin
  input wire logic timer_pin_in
);
  import pdct_pkg::*;

  localparam int DIV_W = (INSTR_DIV > 1) ? $clog2(INSTR_DIV) : 1;
  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(INSTR_DIV - 1);
  localparam logic [DIV_W-1:0] DIV_ZERO = '0;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  // mode, gate, select are never reset; power-up value only
  logic [5:0] cfg_r = CFG_INIT;
  logic req_r;
  logic mask_r;
  logic [7:0] cnt_r;
  logic [7:0] cnt_nxt;
  logic [PRE_W-1:0] pre_r;
  logic [DIV_W-1:0] div_r;
  logic instr_tick_r;
  logic [2:0] pin_sync_r;
  logic pin_level_r;
  logic pin_fall;
  logic pre_in_tick;
  logic cnt_tick;
  logic zero_hit;
  logic [SEL_CODES-1:0] taps;
  logic [7:0] rd_data_r;
  logic irq_r;

  logic wr_count;
  logic wr_ctrl;
  logic rd_any;
  logic [1:0] mode;
  logic [2:0] sel;
  logic [7:0] ctrl_view;

  assign wr_count = bus_in.wr && (bus_in.addr == ADDR_COUNT);
  assign wr_ctrl = bus_in.wr && (bus_in.addr == ADDR_CTRL);
  assign rd_any = bus_in.rd;
  assign mode = {cfg_r[BIT_SRC], cfg_r[BIT_GATE]};
  assign sel = cfg_r[SEL_HI:SEL_LO];

  // ----------------------------------------------------------------
  // instruction cycle clock
  // ----------------------------------------------------------------
  // one-cycle enable, runs on through stop since only reset halts it
  always_ff @(posedge mclk_in)
  begin
    if (sys_rst_in)
    begin
      div_r <= DIV_ZERO;
      instr_tick_r <= 1'b0;
    end
    else if (div_r == DIV_LAST)
    begin
      div_r <= DIV_ZERO;
      instr_tick_r <= 1'b1;
    end
    else
    begin
      div_r <= div_r + DIV_W'(1);
      instr_tick_r <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // timer pin synchroniser
  // ----------------------------------------------------------------
  // stage 0 feeds stage 1 only; level moves once stages 1 and 2 agree
  always_ff @(posedge mclk_in)
  begin
    if (sys_rst_in)
    begin
      pin_sync_r <= 3'h0;
      pin_level_r <= 1'b0;
    end
    else
    begin
      pin_sync_r <= {pin_sync_r[1:0], timer_pin_in};
      if (pin_sync_r[1] == pin_sync_r[2])
      begin
        pin_level_r <= pin_sync_r[2];
      end
    end
  end

  assign pin_fall = pin_level_r && (pin_sync_r[1] == pin_sync_r[2]) && !pin_sync_r[2];

  // ----------------------------------------------------------------
  // prescaler input selection
  // ----------------------------------------------------------------
  always_comb
  begin
    pre_in_tick = 1'b0;
    unique case (mode)
      MODE_INT: pre_in_tick = instr_tick_r;
      MODE_AND: pre_in_tick = instr_tick_r && pin_level_r;
      MODE_OFF: pre_in_tick = 1'b0;
      MODE_PIN: pre_in_tick = pin_fall;
    endcase
  end

  // ----------------------------------------------------------------
  // prescaler
  // ----------------------------------------------------------------
  // a tap fires when the low n prescaler bits are all ones
  genvar gi;
  generate
    for (gi = 0; gi < SEL_CODES; gi++)
    begin : g_tap
      localparam logic [PRE_W-1:0] TAP_MASK = PRE_W'((1 << gi) - 1);
      assign taps[gi] = ((pre_r & TAP_MASK) == TAP_MASK);
    end
  endgenerate

  assign cnt_tick = pre_in_tick && taps[sel];

  // not visible on the bus at all; only a control write with the clear bit set touches it
  always_ff @(posedge mclk_in)
  begin
    if (sys_rst_in)
    begin
      pre_r <= '0;
    end
    else if (wr_ctrl && bus_in.wdata[BIT_PCLR])
    begin
      pre_r <= '0;
    end
    else if (pre_in_tick)
    begin
      pre_r <= pre_r + PRE_W'(1);
    end
  end

  // ----------------------------------------------------------------
  // down counter
  // ----------------------------------------------------------------
  assign zero_hit = cnt_tick && !wr_count && (cnt_r == CNT_ONE);

  always_comb
  begin
    cnt_nxt = cnt_r;
    if (wr_count)
    begin
      cnt_nxt = bus_in.wdata;
    end
    else if (cnt_tick)
    begin
      cnt_nxt = cnt_r - CNT_ONE;
    end
  end

  // value after reset or stop is meaningless until software loads it
  always_ff @(posedge mclk_in)
  begin
    if (sys_rst_in || stop_exec_in)
    begin
      cnt_r <= CNT_JUNK;
    end
    else
    begin
      cnt_r <= cnt_nxt;
    end
  end

  // ----------------------------------------------------------------
  // control register
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_in)
  begin
    if (wr_ctrl)
    begin
      cfg_r <= bus_in.wdata[5:0];
    end
  end

  // set beats a software clear; stop beats everything
  always_ff @(posedge mclk_in)
  begin
    if (sys_rst_in || stop_exec_in)
    begin
      req_r <= 1'b0;
    end
    else if (zero_hit)
    begin
      req_r <= 1'b1;
    end
    else if (wr_ctrl)
    begin
      req_r <= bus_in.wdata[BIT_REQ];
    end
  end

  always_ff @(posedge mclk_in)
  begin
    if (sys_rst_in || stop_exec_in)
    begin
      mask_r <= 1'b1;
    end
    else if (wr_ctrl)
    begin
      mask_r <= bus_in.wdata[BIT_MASK];
    end
  end

  always_comb
  begin
    ctrl_view = {req_r, mask_r, cfg_r};
    ctrl_view[BIT_PCLR] = 1'b0;
  end

  // ----------------------------------------------------------------
  // read port
  // ----------------------------------------------------------------
  // sampled at the strobe so the byte holds for the next cycle while the count moves on; zero otherwise
  always_ff @(posedge mclk_in)
  begin
    if (sys_rst_in)
    begin
      rd_data_r <= BYTE_ZERO;
    end
    else if (rd_any)
    begin
      unique case (bus_in.addr)
        ADDR_COUNT: rd_data_r <= cnt_r;
        ADDR_CTRL: rd_data_r <= ctrl_view;
        default: rd_data_r <= BYTE_ZERO;
      endcase
    end
    else
    begin
      rd_data_r <= BYTE_ZERO;
    end
  end

  // ----------------------------------------------------------------
  // interrupt request
  // ----------------------------------------------------------------
  // a level; the core finishes its instruction, stacks, then vectors
  always_ff @(posedge mclk_in)
  begin
    if (sys_rst_in || stop_exec_in)
    begin
      irq_r <= 1'b0;
    end
    else
    begin
      irq_r <= req_r && !mask_r && !cpu_imask_in;
    end
  end

  assign rd_data_out = rd_data_r;
  assign timer_irq_out = irq_r;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  irq_gate_a:
    assert property (@(posedge mclk_in) disable iff (sys_rst_in)
      timer_irq_out |-> $past(req_r) && !$past(mask_r) && !$past(cpu_imask_in))
    else $error("irq without request or with mask");

  irq_raise_a:
    assert property (@(posedge mclk_in) disable iff (sys_rst_in)
      (req_r && !mask_r && !cpu_imask_in && !stop_exec_in) |=> timer_irq_out)
    else $error("irq not raised");

  zero_set_a:
    assert property (@(posedge mclk_in) disable iff (sys_rst_in)
      (zero_hit && !stop_exec_in) |=> req_r && (cnt_r == BYTE_ZERO))
    else $error("zero not flagged");

  count_down_a:
    assert property (@(posedge mclk_in) disable iff (sys_rst_in)
      (cnt_tick && !wr_count && !stop_exec_in) |=> cnt_r == $past(cnt_r) - CNT_ONE)
    else $error("counter did not decrement");

  past_zero_a:
    assert property (@(posedge mclk_in) disable iff (sys_rst_in)
      (cnt_r == BYTE_ZERO && cnt_tick && !wr_count && !stop_exec_in) |=> cnt_r == CNT_JUNK)
    else $error("counter stopped at zero");

  hold_count_a:
    assert property (@(posedge mclk_in) disable iff (sys_rst_in)
      (mode == MODE_OFF && !wr_count && !wr_ctrl && !stop_exec_in) |=> $stable(cnt_r))
    else $error("counter moved while disabled");

  load_wins_a:
    assert property (@(posedge mclk_in) disable iff (sys_rst_in)
      (wr_count && !stop_exec_in) |=> cnt_r == $past(bus_in.wdata))
    else $error("load lost");

  read_count_a:
    assert property (@(posedge mclk_in) disable iff (sys_rst_in)
      (bus_in.rd && bus_in.addr == ADDR_COUNT) |=> rd_data_out == $past(cnt_r))
    else $error("count readback wrong");

  pclr_zero_a:
    assert property (@(posedge mclk_in) disable iff (sys_rst_in)
      (bus_in.rd && bus_in.addr == ADDR_CTRL) |=> !rd_data_out[BIT_PCLR])
    else $error("clear bit read as one");

  pre_clear_a:
    assert property (@(posedge mclk_in) disable iff (sys_rst_in)
      (wr_ctrl && bus_in.wdata[BIT_PCLR]) |=> pre_r == '0)
    else $error("prescaler not cleared");

  req_sticky_a:
    assert property (@(posedge mclk_in) disable iff (sys_rst_in)
      (req_r && !wr_ctrl && !stop_exec_in) |=> req_r)
    else $error("request dropped by itself");

  stop_mask_a:
    assert property (@(posedge mclk_in) disable iff (sys_rst_in)
      stop_exec_in |=> mask_r && !req_r ##1 !timer_irq_out)
    else $error("stop left interrupt live");

  ext_fall_a:
    assert property (@(posedge mclk_in) disable iff (sys_rst_in)
      (mode == MODE_PIN && pre_in_tick) |-> $past(pin_level_r) && pin_fall)
    else $error("pin count without falling edge");

  and_gate_a:
    assert property (@(posedge mclk_in) disable iff (sys_rst_in)
      (mode == MODE_AND && !pin_level_r && !wr_ctrl && !wr_count && !stop_exec_in)
      |=> $stable(pre_r) && $stable(cnt_r))
    else $error("gated count with pin low");

  int_tick_a:
    assert property (@(posedge mclk_in) disable iff (sys_rst_in)
      (mode == MODE_INT) |-> (pre_in_tick == instr_tick_r))
    else $error("internal tick mismatch");

  rst_mask_a:
    assert property (@(posedge mclk_in)
      sys_rst_in |=> mask_r && !req_r)
    else $error("reset left mask clear");

  stop_junk_a:
    assert property (@(posedge mclk_in) disable iff (sys_rst_in)
      stop_exec_in |=> cnt_r == CNT_JUNK)
    else $error("stop left counter value");

  mask_hold_a:
    assert property (@(posedge mclk_in) disable iff (sys_rst_in)
      (!mask_r && !wr_ctrl && !stop_exec_in) |=> !mask_r)
    else $error("mask set by itself");

  mask_block_a:
    assert property (@(posedge mclk_in) disable iff (sys_rst_in)
      mask_r |=> !timer_irq_out)
    else $error("irq through mask");

  cfg_keep_a:
    assert property (@(posedge mclk_in)
      (sys_rst_in && !wr_ctrl) |=> $stable(cfg_r))
    else $error("reset touched mode bits");

  rd_idle_a:
    assert property (@(posedge mclk_in) disable iff (sys_rst_in)
      !bus_in.rd |=> rd_data_out == BYTE_ZERO)
    else $error("read data outside read cycle");

endmodule : pdct_timer

// >>> testbench/pdct_pin_model.sv
`timescale 1ns/100ps
module pdct_pin_model (
  // clock
  input wire logic mclk_in,
  // pin behaviour: 0 low, 1 high, 2 toggle
  input wire logic [1:0] pin_mode_in,
  // timer pin and its falling-edge tally
  output logic pin_out,
  output int fall_cnt_out
);
  // ----------------------------------------------------------------
  // pin driver
  // ----------------------------------------------------------------
  logic [1:0] ph_r;
  logic pin_nxt;

  initial
  begin
    pin_out = 1'b0;
    fall_cnt_out = 0;
    ph_r = 2'h0;
  end

  // moves only on a 3-mclk phase boundary in every mode, so no level
  // is ever shorter than the filter needs, not even a forced stop
  always @(posedge mclk_in)
  begin
    ph_r <= (ph_r == 2'h2) ? 2'h0 : ph_r + 2'h1;
    case (pin_mode_in)
      2'h0: pin_nxt = 1'b0;
      2'h1: pin_nxt = 1'b1;
      default: pin_nxt = ~pin_out;
    endcase
    if (ph_r == 2'h2)
    begin
      if (pin_out && !pin_nxt)
        fall_cnt_out <= fall_cnt_out + 1;
      pin_out <= pin_nxt;
    end
  end
endmodule : pdct_pin_model

// >>> testbench/tb_top.sv
`timescale 1ns/100ps
module tb_top;
  import pdct_pkg::*;
  localparam int ID = 2;
  logic mclk_in = 1'b0;
  logic sys_rst_in = 1'b1;
  pdct_bus_req_t bus = '0;
  logic [7:0] rd_data;
  logic cpu_imask = 1'b1;
  logic stop_exec = 1'b0;
  logic irq;
  logic pin;
  logic [1:0] pin_mode = 2'h2;
  int fall_cnt;
  int f0;
  int num_errors = 0;
  int n_checks = 0;
  logic [15:0] exp_q[$];
  logic [15:0] e;
  logic pend = 1'b0;
  logic [31:0] seed = 32'hea01;
  logic [7:0] v;

  always #20 mclk_in = ~mclk_in;

  pdct_timer #(.INSTR_DIV(ID)) i_pdct_timer (.mclk_in(mclk_in), .sys_rst_in(sys_rst_in),
    .bus_in(bus), .rd_data_out(rd_data), .cpu_imask_in(cpu_imask),
    .stop_exec_in(stop_exec), .timer_irq_out(irq), .timer_pin_in(pin));
  pdct_pin_model i_pdct_pin_model (.mclk_in(mclk_in), .pin_mode_in(pin_mode),
    .pin_out(pin), .fall_cnt_out(fall_cnt));

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function logic [31:0] xorshift();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xorshift

  task give_verdict();
    if (num_errors == 0 && n_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : give_verdict

  task chk(input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task wr(input logic [1:0] a, input logic [7:0] d);
    bus <= '{1'b1, 1'b0, a, d};
    @(posedge mclk_in);
  endtask : wr

  // expected read data as a window lo..hi, exact when both are equal
  task rd(input logic [1:0] a, input logic [7:0] lo, input logic [7:0] hi);
    exp_q.push_back({lo, hi});
    bus <= '{1'b0, 1'b1, a, 8'h00};
    @(posedge mclk_in);
  endtask : rd

  task idle(input int n);
    bus <= '0;
    repeat (n) @(posedge mclk_in);
  endtask : idle

  // ----------------------------------------------------------------
  // read monitor: data stands only in the cycle after the strobe
  // ----------------------------------------------------------------
  always @(posedge mclk_in)
  begin
    if (pend)
    begin
      e = exp_q.pop_front();
      if (e[15:8] == e[7:0])
        chk(rd_data, e[7:0]);
      else
        chk({7'h00, rd_data >= e[15:8] && rd_data <= e[7:0]}, 8'h01);
    end
    pend <= bus.rd;
  end

  initial
  begin
    repeat (30000) @(posedge mclk_in);
    num_errors++;
    give_verdict();
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial
  begin
    repeat (8) @(posedge mclk_in);
    sys_rst_in <= 1'b0;
    idle(2);
    wr(ADDR_CTRL, 8'h68);
    for (int i = 0; i < 4; i++)
    begin
      v = 8'(xorshift());
      wr(ADDR_COUNT, v);
      idle(10);
      rd(ADDR_COUNT, v, v);
      rd(ADDR_COUNT, v, v);
    end
    // every select code: the window spans whole prescaler periods, 12 counts
    for (int s = 0; s < SEL_CODES; s++)
    begin
      wr(ADDR_CTRL, 8'h60);
      wr(ADDR_COUNT, 8'hf0);
      wr(ADDR_CTRL, 8'h48 | 8'(s));
      idle(ID * (1 << s) * 12 - 1);
      wr(ADDR_CTRL, 8'h60);
      rd(ADDR_COUNT, 8'he4, 8'he4);
    end
    wr(ADDR_COUNT, 8'h03);
    wr(ADDR_CTRL, 8'h08);
    idle(12);
    rd(ADDR_CTRL, 8'h80, 8'h80);
    wr(ADDR_CTRL, 8'ha0);
    rd(ADDR_COUNT, 8'hfa, 8'hfe);
    idle(2);
    chk({7'h00, irq}, 8'h00);
    cpu_imask <= 1'b0;
    idle(3);
    chk({7'h00, irq}, 8'h01);
    wr(ADDR_CTRL, 8'he0);
    idle(3);
    chk({7'h00, irq}, 8'h00);
    rd(ADDR_CTRL, 8'he0, 8'he0);
    wr(ADDR_CTRL, 8'h20);
    idle(3);
    chk({7'h00, irq}, 8'h00);
    wr(ADDR_CTRL, 8'ha0);
    idle(3);
    chk({7'h00, irq}, 8'h01);
    stop_exec <= 1'b1;
    idle(1);
    stop_exec <= 1'b0;
    idle(2);
    chk({7'h00, irq}, 8'h00);
    rd(ADDR_CTRL, 8'h60, 8'h60);
    wr(2'h2, 8'hff);
    rd(2'h2, 8'h00, 8'h00);
    rd(2'h3, 8'h00, 8'h00);
    rd(ADDR_CTRL, 8'h60, 8'h60);
    wr(ADDR_CTRL, 8'hb7);
    sys_rst_in <= 1'b1;
    idle(2);
    sys_rst_in <= 1'b0;
    idle(1);
    rd(ADDR_CTRL, 8'h77, 8'h77);
    // falling pin edges only, counted by the pin model itself
    pin_mode <= 2'h0;
    wr(ADDR_CTRL, 8'h60);
    wr(ADDR_COUNT, 8'h40);
    idle(8);
    f0 = fall_cnt;
    wr(ADDR_CTRL, 8'h78);
    pin_mode <= 2'h2;
    idle(60);
    pin_mode <= 2'h0;
    idle(8);
    wr(ADDR_CTRL, 8'h60);
    v = 8'h40 - 8'(fall_cnt - f0);
    rd(ADDR_COUNT, v, v);
    wr(ADDR_COUNT, 8'h80);
    wr(ADDR_CTRL, 8'h58);
    idle(30);
    wr(ADDR_CTRL, 8'h60);
    rd(ADDR_COUNT, 8'h80, 8'h80);
    wr(ADDR_CTRL, 8'h58);
    pin_mode <= 2'h1;
    idle(39);
    pin_mode <= 2'h0;
    idle(8);
    wr(ADDR_CTRL, 8'h60);
    rd(ADDR_COUNT, 8'h6a, 8'h6e);
    idle(3);
    give_verdict();
  end
endmodule : tb_top
